// >>> rtl/lpm_pkg.sv
`default_nettype none
package lpm_pkg;
  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {LPM_RUN, LPM_LIGHT, LPM_DEEP} lpm_mode_e;

  // ----------------------------------------------------------------
  // field values and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] OSD_ENABLED = 2'h3;   // detection on
  localparam logic [1:0] OSD_RST = 2'h0;       // detection off after reset
  localparam logic [2:0] LVL_OFF = 3'h0;       // priority level that disables
  localparam logic DIV8_RST = 1'h1;            // cpu starts divided by 8
  localparam logic LSO_OFF_RST = 1'h0;         // low-speed oscillator on
  localparam logic DRIVE_RST = 1'h0;           // oscillator drive low
  localparam logic PIN_SEL_RST = 1'h0;         // oscillator pins as ports
  localparam logic ONCHIP_RST = 1'h1;          // on-chip clock after reset
  localparam int DIV128 = 128;                 // ring clock divider
  localparam int DIV32 = 32;                   // slowest peripheral divider
  localparam int NUM_WAKE = 12;                // wake source lines
  // wake source indices
  localparam int W_KEY = 0;
  localparam int W_INT0 = 1;
  localparam int W_INT1 = 2;
  localparam int W_INT3 = 3;
  localparam int W_VM2 = 4;
  localparam int W_CMP = 5;
  localparam int W_TZ = 6;
  localparam int W_TC = 7;
  localparam int W_OSD = 8;
  localparam int W_TX = 9;
  localparam int W_WDT = 10;
  localparam int W_SIO = 11;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;                // core clock rate
  localparam int OSD_MIN_MHZ = 2;              // least detectable main clock
  // a main clock of 2 MHz toggles at most every 32 core cycles
  localparam int STOP_CYC = (CLK_MHZ / OSD_MIN_MHZ + 1) / 2 + 1;
endpackage : lpm_pkg
`default_nettype wire

// >>> rtl/lpm_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - light sleep halts cpu, oscillators keep running
// - stop-in-wait bit halts divided peripheral clocks
// - sleep opcode enters light sleep
// - pins hold their pre-sleep state
// - stop-in-wait limits wake to external, vm2 and protected watchdog sources
// - light wake keeps previous cpu divider
// - light sleep wake source qualification table
// - deep sleep stops all oscillators
// - deep sleep wake source qualification table
// - clock stop write sets div8 and drive
// - deep sleep drives oscillator output high with oscillator pins selected
// - deep wake runs cpu at divide eight
// - main stop selects on-chip clock, flags, irq
// - shared vector cause indication
// - fast ring select picks fallback oscillator
// - ring clock and divide-128 keep running in light sleep, stop in deep sleep
module lpm_ctrl #(
  parameter int NW = lpm_pkg::NUM_WAKE,              // number of wake lines
  parameter int STOP_CYCLES = lpm_pkg::STOP_CYC      // main clock silence limit
) (
  input wire logic i_clock,                          // core clock
  input wire logic i_reset,                          // sync reset, high
  input wire logic i_sleep_exec,                     // sleep opcode executed
  input wire logic i_all_clock_stop_wr,              // write 1 to all_clock_stop
  input wire logic i_periph_clk_stop_in_wait,        // stop fi in light sleep
  input wire logic i_xin_osc_out_pin_pin_select,            // oscillator pins in use
  input wire logic [1:0] i_osc_stop_detect_enable,   // detection enable field
  input wire logic i_fast_ring_select,               // fallback fast oscillator
  input wire logic i_flag_clear,                     // clear stopped flag
  input wire logic i_onchip_clear,                   // return to main clock
  input wire logic i_cpu_div8_clear,                 // software picks a faster divider
  input wire logic i_lowspeed_osc_off_set,           // software stops low-speed osc
  input wire logic i_global_irq_enable,              // cpu I flag
  input wire logic i_wdt_protect_mode,               // watchdog source protected
  input wire logic i_cmp_one_shot,                   // comparator one-shot mode
  input wire logic i_tx_event_mode,                  // timer X external count
  input wire logic i_int0_unfiltered,                // int0 no filter
  input wire logic i_int3_unfiltered,                // int3 no filter
  input wire logic i_timer_c_input_select,           // int3 request at input
  input wire logic i_sio_ext_clock,                  // serial external clock
  input wire logic i_vm2_filter_disable,             // vm2 filter off
  input wire logic i_vm2_cause_flag,                 // vm2 cause in
  input wire logic i_wdt_cause_flag,                 // watchdog cause in
  input wire logic [NW-1:0] i_wake_req,              // raw wake requests
  input wire logic [3*NW-1:0] i_irq_priority_level,  // levels, 3 bits each
  input wire logic i_main_osc_clk,                   // main oscillator pin
  input wire logic [7:0] i_pins_out,                 // pin values from cpu
  output logic [1:0] o_mode,                         // current power mode
  output logic o_cpu_clk_en,                         // cpu clock gate
  output logic o_wdt_clk_en,                         // watchdog clock gate
  output logic o_periph_clk_en,                      // f1..f32 gate
  output logic o_ring_clk_en,                        // ring clock and /128 gate
  output logic o_osc_run,                            // oscillators run
  output logic o_cpu_div8_select,                    // cpu divide by 8
  output logic o_main_osc_drive_high,                // oscillator drive high
  output logic o_lowspeed_osc_off,                   // low-speed osc off
  output logic o_onchip_clock_select,                // on-chip clock in use
  output logic o_main_clock_stopped_flag,            // main clock stopped
  output logic o_fast_ring_active,                   // fallback is fast osc
  output logic o_osd_irq,                            // detection interrupt pulse
  output logic o_osd_cause,                          // shared vector: osd
  output logic o_wdt_cause,                          // shared vector: watchdog
  output logic o_vm2_cause,                          // shared vector: vm2
  output logic o_wake_irq,                           // wake interrupt pulse
  output logic [7:0] o_pins,                         // pin values to pads
  output logic o_osc_out,                            // osc out pin value
  output logic o_osc_out_oe                          // osc out pin enable
);

  // ----------------------------------------------------------------
  // qualification of each wake source
  // ----------------------------------------------------------------
  // which sources may wake the given sleep kind
  function automatic logic [NW-1:0] wake_ok(input logic deep, input logic pstop,
                                            input logic [NW-1:0] req);
    logic [NW-1:0] ok;
    ok = '0;
    if (!deep) begin
      ok[lpm_pkg::W_KEY] = 1'b1;
      ok[lpm_pkg::W_VM2] = 1'b1;
      ok[lpm_pkg::W_INT1] = 1'b1;
      ok[lpm_pkg::W_INT0] = !pstop || i_int0_unfiltered;
      ok[lpm_pkg::W_INT3] = !pstop || i_int3_unfiltered;
      ok[lpm_pkg::W_CMP] = !pstop && i_cmp_one_shot;
      ok[lpm_pkg::W_TZ] = !pstop;
      ok[lpm_pkg::W_TC] = !pstop;
      ok[lpm_pkg::W_OSD] = !pstop;
      ok[lpm_pkg::W_TX] = !pstop || i_tx_event_mode;
      ok[lpm_pkg::W_WDT] = i_wdt_protect_mode;
      ok[lpm_pkg::W_SIO] = !pstop || i_sio_ext_clock;
    end else begin
      ok[lpm_pkg::W_KEY] = 1'b1;
      ok[lpm_pkg::W_INT0] = i_int0_unfiltered;
      ok[lpm_pkg::W_INT1] = 1'b1;
      ok[lpm_pkg::W_INT3] = i_int3_unfiltered && i_timer_c_input_select;
      ok[lpm_pkg::W_TX] = i_tx_event_mode;
      ok[lpm_pkg::W_SIO] = i_sio_ext_clock;
      ok[lpm_pkg::W_VM2] = i_vm2_filter_disable;
    end
    return ok & req;
  endfunction : wake_ok

  // ----------------------------------------------------------------
  // enabled requests
  // ----------------------------------------------------------------
  logic [NW-1:0] lvl_on; // nonzero level per source
  genvar g;
  generate
    for (g = 0; g < NW; g = g + 1) begin : g_lvl
      assign lvl_on[g] = i_irq_priority_level[3*g +: 3] != lpm_pkg::LVL_OFF;
    end
  endgenerate

  lpm_pkg::lpm_mode_e mode; // power mode
  logic wake; // qualified wake this cycle
  // disabled sources never wake, so a reset-only exit works
  assign wake = i_global_irq_enable &&
                (|wake_ok(mode == lpm_pkg::LPM_DEEP, i_periph_clk_stop_in_wait,
                          i_wake_req & lvl_on));

  // ----------------------------------------------------------------
  // mode machine
  // ----------------------------------------------------------------
  // entry by opcode or register write, exit on qualified wake
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mode <= lpm_pkg::LPM_RUN;
    end else begin
      case (mode)
        lpm_pkg::LPM_RUN: begin
          if (i_all_clock_stop_wr) begin
            mode <= lpm_pkg::LPM_DEEP;
          end else if (i_sleep_exec) begin
            mode <= lpm_pkg::LPM_LIGHT;
          end
        end
        default: begin
          if (wake) begin
            mode <= lpm_pkg::LPM_RUN;
          end
        end
      endcase
    end
  end

  // wake interrupt request, one cycle on exit
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_wake_irq <= 1'b0;
    end else begin
      o_wake_irq <= mode != lpm_pkg::LPM_RUN && wake;
    end
  end

  // ----------------------------------------------------------------
  // clock gates
  // ----------------------------------------------------------------
  assign o_mode = mode;
  assign o_cpu_clk_en = mode == lpm_pkg::LPM_RUN;
  assign o_wdt_clk_en = (mode == lpm_pkg::LPM_RUN) ||
                        (mode == lpm_pkg::LPM_LIGHT && i_wdt_protect_mode);
  assign o_periph_clk_en = (mode == lpm_pkg::LPM_RUN) ||
                           (mode == lpm_pkg::LPM_LIGHT && !i_periph_clk_stop_in_wait);
  assign o_ring_clk_en = mode != lpm_pkg::LPM_DEEP;
  assign o_osc_run = mode != lpm_pkg::LPM_DEEP;

  // ----------------------------------------------------------------
  // clock setting bits
  // ----------------------------------------------------------------
  // divider is set on deep entry and cleared by software, light wake keeps it
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_cpu_div8_select <= lpm_pkg::DIV8_RST;
      o_main_osc_drive_high <= lpm_pkg::DRIVE_RST;
    end else if (mode == lpm_pkg::LPM_RUN && i_all_clock_stop_wr) begin
      o_cpu_div8_select <= 1'b1;
      o_main_osc_drive_high <= 1'b1;
    end else if (i_cpu_div8_clear) begin
      // deep entry wins over a software clear in the same cycle
      o_cpu_div8_select <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // pads freeze at the value seen when sleep began
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_pins <= 8'h00;
    end else if (mode == lpm_pkg::LPM_RUN) begin
      o_pins <= i_pins_out;
    end
  end

  assign o_osc_out = 1'b1;
  // driven high only in deep sleep with oscillator pins selected
  assign o_osc_out_oe = mode == lpm_pkg::LPM_DEEP && i_xin_osc_out_pin_pin_select;

  // ----------------------------------------------------------------
  // oscillator stop detection
  // ----------------------------------------------------------------
  logic [2:0] osc_sync; // three stage synchroniser
  logic [$clog2(STOP_CYCLES+1)-1:0] quiet; // cycles without a main edge
  logic osd_on; // detection armed
  logic main_stop; // silence reached
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      osc_sync <= 3'h0;
    end else begin
      osc_sync <= {osc_sync[1:0], i_main_osc_clk};
    end
  end

  // below 2 MHz the silence limit trips falsely, software must disarm
  assign osd_on = i_osc_stop_detect_enable == lpm_pkg::OSD_ENABLED &&
                  !o_onchip_clock_select;
  assign main_stop = osd_on && quiet == STOP_CYCLES[$bits(quiet)-1:0];

  // count while stages two and three agree
  always_ff @(posedge i_clock) begin
    if (i_reset || !osd_on || osc_sync[2] != osc_sync[1]) begin
      quiet <= '0;
    end else if (!main_stop) begin
      quiet <= quiet + 1'b1;
    end
  end

  // on stop: on-chip clock, flag, low-speed on, interrupt; set beats clear
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_onchip_clock_select <= lpm_pkg::ONCHIP_RST;
      o_main_clock_stopped_flag <= 1'b0;
      o_lowspeed_osc_off <= lpm_pkg::LSO_OFF_RST;
      o_osd_irq <= 1'b0;
      o_fast_ring_active <= 1'b0;
    end else begin
      o_osd_irq <= main_stop;
      if (main_stop) begin
        o_onchip_clock_select <= 1'b1;
        o_main_clock_stopped_flag <= 1'b1;
        o_lowspeed_osc_off <= 1'b0;
        o_fast_ring_active <= i_fast_ring_select;
      end else begin
        if (i_onchip_clear) begin
          o_onchip_clock_select <= 1'b0;
        end
        if (i_flag_clear) begin
          o_main_clock_stopped_flag <= 1'b0;
        end
        // a stop in the same cycle wins, the fallback needs this oscillator
        if (i_lowspeed_osc_off_set) begin
          o_lowspeed_osc_off <= 1'b1;
        end
      end
    end
  end

  // shared vector cause bits
  assign o_osd_cause = o_main_clock_stopped_flag ||
                       (i_osc_stop_detect_enable == lpm_pkg::OSD_ENABLED &&
                        o_onchip_clock_select);
  assign o_wdt_cause = i_wdt_cause_flag;
  assign o_vm2_cause = i_vm2_cause_flag;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_LIGHT_ENTRY: assert property (@(posedge i_clock) disable iff (i_reset)
    mode == lpm_pkg::LPM_RUN && i_sleep_exec && !i_all_clock_stop_wr
    |=> mode == lpm_pkg::LPM_LIGHT && !o_cpu_clk_en)
    else $error("light sleep not entered");
  AST_DEEP_DIV8: assert property (@(posedge i_clock) disable iff (i_reset)
    mode == lpm_pkg::LPM_RUN && i_all_clock_stop_wr
    |=> o_cpu_div8_select && o_main_osc_drive_high && !o_osc_run)
    else $error("deep entry bits wrong");
  AST_PSTOP: assert property (@(posedge i_clock) disable iff (i_reset)
    mode == lpm_pkg::LPM_LIGHT && i_periph_clk_stop_in_wait |-> !o_periph_clk_en)
    else $error("peripheral clock running");
  AST_RING: assert property (@(posedge i_clock) disable iff (i_reset)
    mode == lpm_pkg::LPM_LIGHT |-> o_ring_clk_en && o_osc_run)
    else $error("ring clock stopped in light sleep");
  AST_PIN_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
    mode != lpm_pkg::LPM_RUN && $past(mode) != lpm_pkg::LPM_RUN |-> $stable(o_pins))
    else $error("pins moved in sleep");
  AST_NO_WAKE_OFF: assert property (@(posedge i_clock) disable iff (i_reset)
    mode != lpm_pkg::LPM_RUN && !i_global_irq_enable |=> mode == $past(mode))
    else $error("woke with interrupts off");
  AST_LIGHT_DIV: assert property (@(posedge i_clock) disable iff (i_reset)
    mode == lpm_pkg::LPM_LIGHT ##1 mode == lpm_pkg::LPM_RUN
    |-> $stable(o_cpu_div8_select))
    else $error("divider changed on light wake");
  AST_OSD: assert property (@(posedge i_clock) disable iff (i_reset)
    main_stop |=> o_onchip_clock_select && o_main_clock_stopped_flag && o_osd_irq
                  && !o_lowspeed_osc_off)
    else $error("stop detection effects missing");
  AST_OSC_OUT_PIN: assert property (@(posedge i_clock) disable iff (i_reset)
    mode == lpm_pkg::LPM_DEEP |-> o_osc_out_oe == i_xin_osc_out_pin_pin_select)
    else $error("oscillator output pin wrong");
endmodule : lpm_ctrl
`default_nettype wire

// >>> dv/lpm_far_side.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// far side: cpu software, wake sources and main oscillator
// ----------------------------------------------------------------
module lpm_far_side (
  input wire logic i_clock,         // core clock
  input wire logic i_osc_run,       // main oscillator allowed to swing
  input wire logic i_wake_irq,      // wake acknowledge from the block
  input wire logic i_fire,          // start one wake request
  input wire logic [3:0] i_idx,     // source index to raise
  input wire logic [3:0] i_dly,     // cycles before raising, slow answer
  input wire logic i_drop,          // withdraw every request
  output logic [11:0] o_wake_req,   // level requests
  output var logic o_main_osc       // main oscillator pin
);
  logic pend;       // request waiting out its delay
  logic [3:0] cnt;  // delay left
  logic [3:0] idx;  // latched source
  // a request stays up until acknowledged, like an unserviced request bit
  always_ff @(posedge i_clock) begin
    if (i_drop) begin
      o_wake_req <= 12'h000;
      pend <= 1'b0;
    end else if (i_fire) begin
      pend <= 1'b1;
      cnt <= i_dly;
      idx <= i_idx;
    end else if (pend && cnt == 4'h0) begin
      o_wake_req[idx] <= 1'b1;
      pend <= 1'b0;
    end else if (pend) begin
      cnt <= cnt - 4'h1;
    end else if (i_wake_irq) begin
      o_wake_req <= 12'h000;
    end
  end
  // 62.5 MHz swing, far above the least detectable rate; a stop holds the level
  initial begin
    o_main_osc = 1'b0;
    forever begin
      #8;
      if (i_osc_run) o_main_osc = ~o_main_osc;
    end
  end
endmodule : lpm_far_side
`default_nettype wire

// >>> dv/lpm_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module lpm_ctrl_tb_top;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic i_clock = 1'b0;  // core clock
  logic i_reset = 1'b1;  // sync reset
  logic sleep = 1'b0, acs = 1'b0, pstop = 1'b0, xsel = 1'b0, fast = 1'b0;
  logic fclr = 1'b0, oclr = 1'b0, gie = 1'b1, wprot = 1'b0, i0nf = 1'b0, i3nf = 1'b0;
  logic tcsel = 1'b0, vmc = 1'b0, wdc = 1'b0, osc_run = 1'b1, fire = 1'b0, drop = 1'b1;
  logic cmp1 = 1'b0, txev = 1'b0, sioext = 1'b0, vmfd = 1'b0;  // wake qualifiers
  logic dclr = 1'b0, lsoset = 1'b0;  // software clock-bit pulses
  logic [1:0] osd_en = 2'h0;  // detection enable field
  logic [35:0] lvl = {12{3'h1}};  // every source enabled at level 1
  logic [7:0] pins = 8'h00;  // pin values from the core
  logic [3:0] fidx = 4'h0, fdly = 4'h0;
  logic [11:0] wreq;
  logic [7:0] pads;
  logic [1:0] mode;
  logic mosc, cpu_en, wdt_en, per_en, ring_en, osc_on, div8, drv, lso_off, onchip, sflag;
  logic fra, osd_irq, osd_c, wdt_c, vm2_c, wirq, xo, xo_oe;
  int n_errors = 0;
  int samples_checked = 0;
  always #4 i_clock = ~i_clock;
  // short silence limit keeps the detection wait small
  lpm_ctrl #(.STOP_CYCLES(4)) uut (.i_clock(i_clock), .i_reset(i_reset),
    .i_sleep_exec(sleep), .i_all_clock_stop_wr(acs), .i_periph_clk_stop_in_wait(pstop),
    .i_xin_osc_out_pin_pin_select(xsel), .i_osc_stop_detect_enable(osd_en), .i_fast_ring_select(fast),
    .i_flag_clear(fclr), .i_onchip_clear(oclr), .i_global_irq_enable(gie),
    .i_cpu_div8_clear(dclr), .i_lowspeed_osc_off_set(lsoset),
    .i_wdt_protect_mode(wprot), .i_cmp_one_shot(cmp1), .i_tx_event_mode(txev),
    .i_int0_unfiltered(i0nf), .i_int3_unfiltered(i3nf), .i_timer_c_input_select(tcsel),
    .i_sio_ext_clock(sioext), .i_vm2_filter_disable(vmfd), .i_vm2_cause_flag(vmc),
    .i_wdt_cause_flag(wdc), .i_wake_req(wreq), .i_irq_priority_level(lvl),
    .i_main_osc_clk(mosc), .i_pins_out(pins), .o_mode(mode), .o_cpu_clk_en(cpu_en),
    .o_wdt_clk_en(wdt_en), .o_periph_clk_en(per_en), .o_ring_clk_en(ring_en),
    .o_osc_run(osc_on), .o_cpu_div8_select(div8), .o_main_osc_drive_high(drv),
    .o_lowspeed_osc_off(lso_off), .o_onchip_clock_select(onchip),
    .o_main_clock_stopped_flag(sflag), .o_fast_ring_active(fra), .o_osd_irq(osd_irq),
    .o_osd_cause(osd_c), .o_wdt_cause(wdt_c), .o_vm2_cause(vm2_c), .o_wake_irq(wirq),
    .o_pins(pads), .o_osc_out(xo), .o_osc_out_oe(xo_oe));
  lpm_far_side far (.i_clock(i_clock), .i_osc_run(osc_run), .i_wake_irq(wirq),
    .i_fire(fire), .i_idx(fidx), .i_dly(fdly), .i_drop(drop), .o_wake_req(wreq),
    .o_main_osc(mosc));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task tick;  // inputs change and outputs are read 1 ns after the edge
    @(posedge i_clock);
    #1;
  endtask : tick
  task chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task fire_src(input int s, input logic [3:0] d);
    fidx = 4'(s);
    fdly = d;
    fire = 1'b1;
    tick;
    fire = 1'b0;
  endtask : fire_src
  task await_wake;  // bounded wait for the return to run
    int k;
    k = 0;
    while (mode !== 2'h0 && k < 20) begin
      tick;
      k++;
    end
    chk(mode, 8'h00, "back in run");
    chk(wirq, 8'h01, "wake pulse");
    tick;
    chk(wirq, 8'h00, "wake pulse one cycle");
  endtask : await_wake
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk({mode, div8, onchip, sflag, lso_off, drv}, 8'h18, "reset state");
    chk({cpu_en, xo_oe, osd_irq, wirq}, 8'h08, "reset gates");
    $display("test reset done");
  endtask : t_reset
  task t_light;  // wake path with a disabled source and a masked cpu first
    pins = 8'h5A;
    wprot = 1'b1;
    dclr = 1'b1;  // run undivided so that a kept divider is visible
    lvl[3*lpm_pkg::W_KEY +: 3] = lpm_pkg::LVL_OFF;
    tick;
    dclr = 1'b0;
    sleep = 1'b1;
    tick;
    sleep = 1'b0;
    pins = 8'hC3;
    chk(mode, 8'h01, "light entry");
    chk({cpu_en, wdt_en, per_en, ring_en, osc_on}, 8'h0F, "light gates");
    tick;
    chk(pads, 8'h5A, "pins held");
    fire_src(lpm_pkg::W_KEY, 4'h3);
    repeat (8) tick;
    chk(mode, 8'h01, "zero level ignored");
    gie = 1'b0;
    lvl[3*lpm_pkg::W_KEY +: 3] = 3'h2;
    repeat (3) tick;
    chk(mode, 8'h01, "masked cpu ignored");
    gie = 1'b1;
    await_wake;
    chk(div8, 8'h00, "divider kept");
    chk(pads, 8'hC3, "pins follow after wake");
    wprot = 1'b0;
    $display("test light done");
  endtask : t_light
  task t_pstop;  // detection is off, so stopping peripheral clocks is allowed
    pstop = 1'b1;
    sleep = 1'b1;
    tick;
    sleep = 1'b0;
    chk({mode, wdt_en, per_en, ring_en}, 8'h09, "stopped periph clocks");
    fire_src(lpm_pkg::W_TZ, 4'h0);
    repeat (5) tick;
    chk(mode, 8'h01, "internal timer cannot wake");
    drop = 1'b1;
    tick;
    drop = 1'b0;
    i0nf = 1'b1;
    fire_src(lpm_pkg::W_INT0, 4'h1);
    await_wake;
    pstop = 1'b0;
    i0nf = 1'b0;
    $display("test stop-in-wait done");
  endtask : t_pstop
  task t_deep;
    osd_en = 2'h0;
    xsel = 1'b1;
    acs = 1'b1;
    tick;
    acs = 1'b0;
    chk({mode, div8, drv}, 8'h0B, "deep entry sets divider and drive");
    chk({cpu_en, per_en, ring_en, osc_on}, 8'h00, "all clocks stopped");
    chk({xo, xo_oe}, 8'h03, "oscillator out driven high");
    xsel = 1'b0;
    tick;
    chk(xo_oe, 8'h00, "oscillator out left as input");
    repeat (4) tick;
    i3nf = 1'b1;
    fire_src(lpm_pkg::W_INT3, 4'h0);
    repeat (5) tick;
    chk(mode, 8'h02, "int3 needs input select");
    tcsel = 1'b1;
    await_wake;
    chk(div8, 8'h01, "deep wake at divide by eight");
    i3nf = 1'b0;
    tcsel = 1'b0;
    $display("test deep done");
  endtask : t_deep
  // enter a sleep, raise one source whose qualifier is still off
  task t_hold(input logic deep, input int s);
    acs = deep;
    sleep = !deep;
    tick;
    acs = 1'b0;
    sleep = 1'b0;
    fire_src(s, 4'h0);
    repeat (4) tick;
    chk(mode, deep ? 8'h02 : 8'h01, "unqualified source held back");
  endtask : t_hold
  task t_quals;  // five mode qualifiers open their sources: vm2, tx and sio in deep sleep, cmp and wdt in light sleep
    t_hold(1'b1, lpm_pkg::W_VM2);
    vmfd = 1'b1;
    await_wake;
    vmfd = 1'b0;
    t_hold(1'b1, lpm_pkg::W_TX);
    txev = 1'b1;
    await_wake;
    txev = 1'b0;
    t_hold(1'b1, lpm_pkg::W_SIO);
    sioext = 1'b1;
    await_wake;
    sioext = 1'b0;
    t_hold(1'b0, lpm_pkg::W_CMP);
    cmp1 = 1'b1;
    await_wake;
    cmp1 = 1'b0;
    t_hold(1'b0, lpm_pkg::W_WDT);
    wprot = 1'b1;
    await_wake;
    wprot = 1'b0;
    $display("test wake qualifiers done");
  endtask : t_quals
  task t_osd(input logic f);  // main clock loss with either fallback
    int k;
    fast = f;
    osc_run = 1'b1;
    osd_en = 2'h3;
    oclr = 1'b1;
    lsoset = 1'b1;
    tick;
    oclr = 1'b0;
    lsoset = 1'b0;
    repeat (10) tick;
    chk({onchip, sflag, osd_c, lso_off}, 8'h01, "main clock unflagged");
    osc_run = 1'b0;
    k = 0;
    while (osd_irq !== 1'b1 && k < 40) begin
      tick;
      k++;
    end
    chk(osd_irq, 8'h01, "stop interrupt");
    chk({onchip, sflag, lso_off}, 8'h06, "fallback clock and flag");
    chk({fra, osd_c}, {f, 1'b1}, "fallback kind");
    fclr = 1'b1;
    tick;
    fclr = 1'b0;
    chk({osd_irq, sflag, osd_c}, 8'h01, "cause via enable and selection");
    osd_en = 2'h0;
    wdc = 1'b1;
    vmc = 1'b1;
    tick;
    chk({osd_c, wdt_c, vm2_c}, 8'h03, "shared vector causes");
    wdc = 1'b0;
    vmc = 1'b0;
    osc_run = 1'b1;
    $display("test oscillator stop done");
  endtask : t_osd
  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_clock);
    #1;
    i_reset = 1'b0;
    drop = 1'b0;
    t_reset;
    t_light;
    t_pstop;
    t_deep;
    t_quals;
    t_osd(1'b0);
    t_osd(1'b1);
    close_out;
  end
  initial begin  // whole run is under two hundred cycles
    #20000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    close_out;
  end
endmodule : lpm_ctrl_tb_top
`default_nettype wire
